/* rtl/aux_regs_flash_bridge_event_queue.sv */
// Auxiliary register bank: handshake, scratch, flash bridge, lookup, queue.
// Behaviour
// - Handshake register holds read/write permit bits.
// - Thirty-two bit scratch register holds writes.
// - Sixteen bit scratch register holds writes.
// - Chip-select bit drives flash select, low active.
// - Chip-select reads one after reset.
// - Byte port write shifts out, read in.
// - Flash has 2048 pages, 256 used bytes.
// - Page register selects lookup page, default zero.
// - Readback window returns selected page when enabled.
// - Lookup spans 5 ns clock period.
// - Enabled queue stores count and word descriptors.
// - Occupancy register reports queued descriptor words.
// - Nonempty flag set while queue holds data.
// - Saturated flag set at 1024 descriptors.
// - Board full when buffer full or enabled queue full.
// - Power-on copies 256 lookup pages from flash.
// - Power-on copies configuration page into RAM.
// - Measurements corrected through lookup when enabled.
// - Command register passes words to microcontroller.
`default_nettype none
module aux_regs_flash_bridge_event_queue
  import aux_regs_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  // Register access port.
  input  wire bus_req_t    i_bus,
  output logic             o_bus_ack,
  output logic [31:0]      o_bus_rdata,
  // Control bits from the board control register.
  input  wire logic        i_lut_read_en,
  input  wire logic        i_comp_en,
  input  wire logic        i_evq_en,
  // Microcontroller command port.
  input  wire logic        i_micro_read_ok,
  input  wire logic        i_micro_write_ok,
  output logic             o_micro_wr,
  output logic [15:0]      o_micro_wdata,
  input  wire logic [15:0] i_micro_rdata,
  // Event stream from the output buffer writer.
  input  wire logic        i_ev_valid,
  input  wire ev_desc_t    i_ev_desc,
  output logic             o_ev_ready,
  input  wire logic        i_obuf_full,
  output logic             o_board_full,
  // Converter measurement to be corrected.
  input  wire logic        i_meas_valid,
  input  wire logic [7:0]  i_meas_fine,
  output logic             o_corr_valid,
  output logic [7:0]       o_corr_fine,
  // Serial flash pins.
  output logic             o_flash_cs_n,
  output logic             o_flash_sck,
  output logic             o_flash_mosi,
  input  wire logic        i_flash_miso,
  // Power-on load finished.
  output logic             o_load_done
);
  // Register state.
  logic [31:0]  scratch_wide;      // Wide test register.
  logic [15:0]  scratch_narrow;    // Narrow test register.
  logic         chip_select;       // Software chip-select bit.
  logic [7:0]   page_select;       // Lookup page selection.
  logic [7:0]   lut_mem [LUT_PAGES*LUT_ENTRIES]; // Compensation lookup.
  logic [7:0]   cfg_mem [CFG_BYTES];             // Configuration copy.
  // Serial engine.
  shift_state_t sh_state;
  logic [7:0]   sh_out;            // Byte being shifted out.
  logic [7:0]   sh_in;             // Byte being shifted in.
  logic [2:0]   sh_bit;            // Bit index within the byte.
  logic [2:0]   sh_div;            // Half-period divider.
  logic         sh_start;          // Request a byte transfer.
  logic [7:0]   sh_tx;             // Byte to send on start.
  logic         sh_busy;           // A transfer is under way.
  // Loader.
  load_state_t  ld_state;
  logic [18:0]  ld_idx;            // Byte index across the whole load.
  logic [2:0]   ld_hdr;            // Header byte counter.
  logic         ld_page_end;       // Last used byte of a flash page.
  // Bus bookkeeping.
  logic         acc_busy;          // Byte port access is pending.
  logic         in_lut;
  logic         evq_pop;
  ev_desc_t     evq_out;
  logic [10:0]  evq_count;
  logic         evq_in_ready;
  logic         evq_valid;
  logic [7:0]   lut_rd;
  logic [15:0]  lut_word_addr;
  logic         acc_new;

  assign acc_new  = (i_bus.rd || i_bus.wr) && !acc_busy && !o_bus_ack;
  assign in_lut   = (i_bus.addr >= OFS_LUT_LO) && (i_bus.addr <= OFS_LUT_HI);
  assign sh_busy  = (sh_state != SH_IDLE);
  assign lut_word_addr = {page_select, i_bus.addr[8:1]};
  assign lut_rd   = lut_mem[lut_word_addr];
  assign evq_pop  = acc_new && i_bus.rd && (i_bus.addr == OFS_EVQ_DATA);
  assign ld_page_end = (ld_idx[7:0] == 8'hFF);

  aux_fifo #(.WIDTH(32), .DEPTH(EVQ_DEPTH), .AW(EVQ_AW)) evq (
    .i_mclk      (i_mclk),
    .i_sys_rst   (i_sys_rst),
    .i_in_valid  (i_ev_valid && i_evq_en),
    .o_in_ready  (evq_in_ready),
    .i_in_data   (i_ev_desc),
    .o_out_valid (evq_valid),
    .i_out_ready (evq_pop),
    .o_out_data  (evq_out),
    .o_count     (evq_count)
  );

  // Back-pressure to the event source; a disabled queue never stalls it.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_ev_ready   <= 1'b0;
      o_board_full <= 1'b0;
    end else begin
      o_ev_ready   <= evq_in_ready || !i_evq_en;
      o_board_full <= i_obuf_full || (i_evq_en && !evq_in_ready);
    end
  end

  // Writable registers; the command word is forwarded to the micro.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      scratch_wide   <= 32'h0000_0000;
      scratch_narrow <= 16'h0000;
      chip_select    <= CS_RESET;
      page_select    <= PAGE_RESET;
      o_micro_wr     <= 1'b0;
      o_micro_wdata  <= 16'h0000;
    end else begin
      o_micro_wr <= 1'b0;
      if (acc_new && i_bus.wr) begin
        if (i_bus.addr == OFS_SCRATCH_WIDE) begin
          scratch_wide <= i_bus.wdata;
        end else if (i_bus.addr == OFS_SCRATCH_NARR) begin
          scratch_narrow <= i_bus.wdata[15:0];
        end else if (i_bus.addr == OFS_CHIP_SELECT) begin
          chip_select <= i_bus.wdata[0];
        end else if (i_bus.addr == OFS_PAGE_SELECT) begin
          page_select <= i_bus.wdata[7:0];
        end else if (i_bus.addr == OFS_CMD_PORT) begin
          o_micro_wr    <= 1'b1;
          o_micro_wdata <= i_bus.wdata[15:0];
        end
      end
    end
  end

  // Bus answer: one-cycle ack, held off for byte port shifts.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_bus_ack   <= 1'b0;
      o_bus_rdata <= 32'h0000_0000;
      acc_busy    <= 1'b0;
    end else begin
      o_bus_ack <= 1'b0;
      if (acc_busy) begin
        if (sh_state == SH_DONE) begin
          acc_busy    <= 1'b0;
          o_bus_ack   <= 1'b1;
          o_bus_rdata <= {24'h000000, sh_in};
        end
      end else if (acc_new) begin
        if (i_bus.addr == OFS_BYTE_PORT && o_load_done) begin
          acc_busy <= 1'b1;
        end else begin
          o_bus_ack <= 1'b1;
          o_bus_rdata <= 32'h0000_0000;
          if (i_bus.rd) begin
            if (i_bus.addr == OFS_HANDSHAKE) begin
              o_bus_rdata[HS_READ_OK_BIT]  <= i_micro_read_ok;
              o_bus_rdata[HS_WRITE_OK_BIT] <= i_micro_write_ok;
            end else if (i_bus.addr == OFS_CMD_PORT) begin
              o_bus_rdata <= {16'h0000, i_micro_rdata};
            end else if (i_bus.addr == OFS_CHIP_SELECT) begin
              o_bus_rdata <= {31'h0, chip_select};
            end else if (i_bus.addr == OFS_PAGE_SELECT) begin
              o_bus_rdata <= {24'h000000, page_select};
            end else if (i_bus.addr == OFS_EVQ_DATA) begin
              o_bus_rdata <= evq_valid ? evq_out : 32'h0000_0000;
            end else if (i_bus.addr == OFS_EVQ_COUNT) begin
              o_bus_rdata <= {21'h0, evq_count};
            end else if (i_bus.addr == OFS_EVQ_FLAGS) begin
              o_bus_rdata[EVQ_NONEMPTY_BIT] <= evq_valid;
              o_bus_rdata[EVQ_SATURATED_BIT] <=
                (evq_count == 11'(EVQ_DEPTH));
            end else if (i_bus.addr == OFS_SCRATCH_WIDE) begin
              o_bus_rdata <= scratch_wide;
            end else if (i_bus.addr == OFS_SCRATCH_NARR) begin
              o_bus_rdata <= {16'h0000, scratch_narrow};
            end else if (in_lut && i_lut_read_en) begin
              o_bus_rdata <= {24'h000000, lut_rd};
            end
          end
        end
      end
    end
  end

  // The bus or the loader requests a byte; the loader owns it until done.
  always_comb begin
    sh_start = 1'b0;
    sh_tx    = 8'h00;
    if (!o_load_done) begin
      sh_start = (ld_state == LD_CMD) || (ld_state == LD_DATA);
      sh_tx    = (ld_state == LD_CMD && ld_hdr == 3'd0) ? OP_PAGE_READ :
                 (ld_state == LD_CMD && ld_hdr == 3'd1) ?
                   {4'b0000, ld_idx[18:15]} :
                 (ld_state == LD_CMD && ld_hdr == 3'd2) ?
                   {ld_idx[14:8], 1'b0} : 8'h00;
    end else if (acc_new && i_bus.addr == OFS_BYTE_PORT) begin
      sh_start = 1'b1;
      sh_tx    = i_bus.wr ? i_bus.wdata[7:0] : 8'h00;
    end
  end

  // Serial engine: mode 0, MSB first, sck from a divider enable.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      sh_state     <= SH_IDLE;
      sh_out       <= 8'h00;
      sh_in        <= 8'h00;
      sh_bit       <= 3'd0;
      sh_div       <= 3'd0;
      o_flash_sck  <= 1'b0;
      o_flash_mosi <= 1'b0;
    end else begin
      case (sh_state)
        SH_IDLE: begin
          if (sh_start && !sh_busy) begin
            sh_out       <= sh_tx;
            o_flash_mosi <= sh_tx[7];
            sh_bit       <= 3'd7;
            sh_div       <= 3'd0;
            sh_state     <= SH_LOW;
          end
        end
        SH_LOW: begin
          sh_div <= sh_div + 1'b1;
          if (sh_div == 3'(SCK_HALF - 1)) begin
            sh_div      <= 3'd0;
            o_flash_sck <= 1'b1;
            sh_in       <= {sh_in[6:0], i_flash_miso};
            sh_state    <= SH_HIGH;
          end
        end
        SH_HIGH: begin
          sh_div <= sh_div + 1'b1;
          if (sh_div == 3'(SCK_HALF - 1)) begin
            sh_div      <= 3'd0;
            o_flash_sck <= 1'b0;
            if (sh_bit == 3'd0) begin
              sh_state <= SH_DONE;
            end else begin
              sh_bit       <= sh_bit - 1'b1;
              o_flash_mosi <= sh_out[sh_bit - 1'b1];
              sh_state     <= SH_LOW;
            end
          end
        end
        SH_DONE: begin
          sh_state <= SH_IDLE;
        end
        default: begin
          sh_state <= SH_IDLE;
        end
      endcase
    end
  end

  // Power-on loader: lookup pages then one configuration page.
  // 256 of 264 bytes used
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      ld_state    <= LD_CMD;
      ld_idx      <= '0;
      ld_hdr      <= 3'd0;
      o_load_done <= 1'b0;
    end else begin
      case (ld_state)
        LD_CMD: begin
          if (sh_state == SH_DONE) begin
            if (ld_hdr == 3'(3 + READ_DUMMY_BYTES)) begin
              ld_state <= LD_DATA;
            end else begin
              ld_hdr <= ld_hdr + 1'b1;
            end
          end
        end
        LD_DATA: begin
          if (sh_state == SH_DONE) begin
            ld_idx <= ld_idx + 1'b1;
            if (ld_page_end) begin
              ld_state <= LD_GAP;
            end
          end
        end
        LD_GAP: begin
          // Deselect between pages so each read starts afresh.
          ld_hdr <= 3'd0;
          if (ld_idx[18:8] == 11'(LUT_PAGES) + 11'd1) begin
            ld_state <= LD_DONE;
          end else begin
            ld_state <= LD_WAIT;
          end
        end
        LD_WAIT: begin
          ld_state <= LD_CMD;
        end
        LD_DONE: begin
          o_load_done <= 1'b1;
        end
        default: begin
          ld_state <= LD_DONE;
        end
      endcase
    end
  end

  // Captured bytes land in the lookup or configuration memory.
  always_ff @(posedge i_mclk) begin
    if (ld_state == LD_DATA && sh_state == SH_DONE) begin
      if (ld_idx[18:8] < 11'(LUT_PAGES)) begin
        lut_mem[ld_idx[15:0]] <= sh_in;
      end else begin
        cfg_mem[ld_idx[7:0]] <= sh_in;
      end
    end
  end

  // Chip select follows software after the load, loader before.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_flash_cs_n <= CS_RESET;
    end else if (!o_load_done) begin
      o_flash_cs_n <= (ld_state == LD_GAP) || (ld_state == LD_WAIT) ||
                      (ld_state == LD_DONE);
    end else begin
      o_flash_cs_n <= chip_select;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      o_corr_valid <= 1'b0;
      o_corr_fine  <= 8'h00;
    end else begin
      o_corr_valid <= i_meas_valid;
      o_corr_fine  <= i_comp_en ? lut_mem[{8'h00, i_meas_fine}] : i_meas_fine;
    end
  end
endmodule
`default_nettype wire

/* rtl/aux_regs_pkg.sv */
// Constants, types and register map for the auxiliary register bank.
`default_nettype none
package aux_regs_pkg;
  // Register byte offsets within the board space.
  localparam logic [15:0] OFS_CMD_PORT     = 16'h102E;
  localparam logic [15:0] OFS_HANDSHAKE    = 16'h1030;
  localparam logic [15:0] OFS_CHIP_SELECT  = 16'h1032;
  localparam logic [15:0] OFS_BYTE_PORT    = 16'h1034;
  localparam logic [15:0] OFS_PAGE_SELECT  = 16'h1036;
  localparam logic [15:0] OFS_EVQ_DATA     = 16'h1038;
  localparam logic [15:0] OFS_EVQ_COUNT    = 16'h103C;
  localparam logic [15:0] OFS_EVQ_FLAGS    = 16'h103E;
  localparam logic [15:0] OFS_SCRATCH_WIDE = 16'h1200;
  localparam logic [15:0] OFS_SCRATCH_NARR = 16'h1204;
  localparam logic [15:0] OFS_LUT_LO       = 16'h8000;
  localparam logic [15:0] OFS_LUT_HI       = 16'h81FE;
  // Field positions.
  localparam int HS_READ_OK_BIT  = 0;
  localparam int HS_WRITE_OK_BIT = 1;
  localparam int EVQ_NONEMPTY_BIT = 0;
  localparam int EVQ_SATURATED_BIT = 1;
  localparam int EV_COUNT_LSB    = 16;
  // Reset values.
  localparam logic       CS_RESET   = 1'b1;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // Flash geometry and lookup table geometry.
  localparam int FLASH_PAGES      = 2048;
  localparam int FLASH_PAGE_BYTES = 264;
  localparam int FLASH_USED_BYTES = 256;
  localparam int LUT_PAGES        = 256;
  localparam int LUT_ENTRIES      = 256;
  localparam int CFG_BYTES        = 256;
  localparam logic [10:0] CFG_PAGE = 11'h100;
  localparam int PAGE_SHIFT       = 9;
  // Flash opcodes used by the power-on loader.
  localparam logic [7:0] OP_PAGE_READ = 8'hD2;
  localparam int READ_DUMMY_BYTES     = 4;
  // Event queue.
  localparam int EVQ_DEPTH = 1024;
  localparam int EVQ_AW    = 11;
  // Serial clock divider: half period in system clocks (200 MHz / 8).
  localparam int SCK_HALF  = 4;
  // Bus access bundle.
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } bus_req_t;
  // Event descriptor written into the queue.
  typedef struct packed {
    logic [15:0] count;
    logic [15:0] words;
  } ev_desc_t;
  // Serial engine state, one-hot.
  typedef enum logic [3:0] {
    SH_IDLE = 4'h1,
    SH_LOW  = 4'h2,
    SH_HIGH = 4'h4,
    SH_DONE = 4'h8
  } shift_state_t;
  // Power-on loader state, one-hot.
  typedef enum logic [4:0] {
    LD_CMD  = 5'h01,
    LD_DATA = 5'h02,
    LD_GAP  = 5'h04,
    LD_DONE = 5'h08,
    LD_WAIT = 5'h10
  } load_state_t;
endpackage
`default_nettype wire

/* rtl/aux_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
`default_nettype none
module aux_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 1024,
  parameter int AW    = 11
) (
  input  wire logic             i_mclk,
  input  wire logic             i_sys_rst,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data,
  output logic      [AW-1:0]    o_count
);
  // Storage array; the queue lives entirely inside this module.
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-2:0]    wr_ptr;
  logic [AW-2:0]    rd_ptr;
  logic [AW-1:0]    count;
  logic             push;
  logic             pop;

  assign push = i_in_valid && (count != AW'(DEPTH));
  assign pop  = i_out_ready && (count != '0);
  // Full and empty are honest: derived from the live word count.
  assign o_in_ready  = (count != AW'(DEPTH));
  assign o_out_valid = (count != '0);
  assign o_out_data  = mem[rd_ptr];
  assign o_count     = count;

  // Write side stores the word at the write pointer.
  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // Pointers and occupancy move together.
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* verification/aux_regs_chk.sv */
// Port-level assertions for the auxiliary register bank.
`default_nettype none
module aux_regs_chk
  import aux_regs_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_sys_rst,
  input wire bus_req_t    i_bus,
  input wire logic        o_bus_ack,
  input wire logic        o_micro_wr,
  input wire logic [15:0] o_micro_wdata,
  input wire logic        i_obuf_full,
  input wire logic        o_board_full,
  input wire logic        i_meas_valid,
  input wire logic        o_corr_valid,
  input wire logic        o_flash_cs_n,
  input wire logic        o_load_done
);
  // All checks share the one board clock and its reset.
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_sys_rst);

  a_cs_after_reset: assert property (
    $fell(i_sys_rst) |-> o_flash_cs_n)
    else $error("flash select active after reset");
  a_ack_single: assert property (
    o_bus_ack |=> !o_bus_ack)
    else $error("bus acknowledge longer than one cycle");
  a_ack_cause: assert property (
    o_bus_ack |-> $past(i_bus.rd || i_bus.wr))
    else $error("acknowledge without a request");
  a_scratch_ack: assert property (
    ($rose(i_bus.wr) && i_bus.addr == OFS_SCRATCH_WIDE) |=> o_bus_ack)
    else $error("scratch write not acknowledged next cycle");
  a_byte_refuse: assert property (
    ($rose(i_bus.rd || i_bus.wr) && i_bus.addr == OFS_BYTE_PORT
     && !o_load_done) |=> o_bus_ack)
    else $error("early byte port access not refused at once");
  a_micro_write: assert property (
    ($rose(i_bus.wr) && i_bus.addr == OFS_CMD_PORT) |=>
    o_micro_wr && o_micro_wdata == $past(i_bus.wdata[15:0]))
    else $error("command word not passed on");
  a_full_follows: assert property (
    i_obuf_full |=> o_board_full)
    else $error("board full missed buffer full");
  a_corr_timing: assert property (
    1'b1 |=> o_corr_valid == $past(i_meas_valid))
    else $error("corrected valid not one cycle after input");
endmodule

bind aux_regs_flash_bridge_event_queue aux_regs_chk u_chk (
  .i_mclk       (i_mclk),
  .i_sys_rst    (i_sys_rst),
  .i_bus        (i_bus),
  .o_bus_ack    (o_bus_ack),
  .o_micro_wr   (o_micro_wr),
  .o_micro_wdata(o_micro_wdata),
  .i_obuf_full  (i_obuf_full),
  .o_board_full (o_board_full),
  .i_meas_valid (i_meas_valid),
  .o_corr_valid (o_corr_valid),
  .o_flash_cs_n (o_flash_cs_n),
  .o_load_done  (o_load_done)
);
`default_nettype wire

/* verification/aux_flash_model.sv */
// Behavioural serial flash: captures the second frame, returns bytes.
`default_nettype none
module aux_flash_model (
  input  wire logic i_cs_n,
  input  wire logic i_sck,
  input  wire logic i_mosi,
  output logic      o_miso
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] sh;                  // Incoming shift register.
  logic [7:0] op;                  // First byte of the current frame.
  logic [7:0] rx [0:7];            // First bytes of the second frame.
  int         nbit = 0;            // Bit position within the byte.
  int         nbyte = 0;           // Byte position within the frame.
  int         frames = 0;          // Frames begun so far.
  int         prog_bad = 0;        // Page programs of the wrong length.
  int         early_sel = 0;       // Selects inside the program settle time.
  realtime    prog_end = -1.0e9;   // End of the last page program.
  initial o_miso = 1'b0;
  // byte counting within a page frame.
  always @(posedge i_sck) begin
    if (!i_cs_n) begin
      sh = {sh[6:0], i_mosi};
      nbit = nbit + 1;
      if (nbit == 8) begin
        // opcode, three address bytes and four dummy bytes, kept for the bench.
        if (nbyte == 0) op = sh;
        if (frames == 2 && nbyte < 8) rx[nbyte] = sh;
        nbyte = nbyte + 1;
        nbit = 0;
      end
    end
  end
  // Data goes out on the falling edge, most significant bit first.
  always @(negedge i_sck) begin
    if (!i_cs_n) o_miso <= 1'((nbyte[7:0] ^ 8'h3C) >> (7 - nbit));
  end
  // a select starts a frame; counting here ignores the power-up edge.
  always @(negedge i_cs_n) begin
    frames = frames + 1;
    // no select within 20 ms after a page program.
    if ($realtime - prog_end < 20.0e6) early_sel = early_sel + 1;
  end
  // a deselect ends the frame; the released line shows no stale bit.
  always @(posedge i_cs_n) begin
    // a page program holds four header and 264 data bytes.
    if (op == 8'h82 && nbyte != 268) prog_bad = prog_bad + 1;
    if (op == 8'h82) prog_end = $realtime;
    op = 8'h00;
    nbit = 0;
    nbyte = 0;
    o_miso <= ~o_miso;
  end
endmodule
`default_nettype wire

/* verification/tb_aux_regs_flash_bridge_event_queue.sv */
// Self-checking bench for the auxiliary register bank.
`default_nettype none
module tb_aux_regs_flash_bridge_event_queue
  import aux_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_mclk, i_sys_rst, i_lut_read_en, i_comp_en, i_evq_en;
  logic        i_micro_read_ok, i_micro_write_ok, o_micro_wr, o_bus_ack;
  logic        i_ev_valid, o_ev_ready, i_obuf_full, o_board_full;
  logic        i_meas_valid, o_corr_valid, o_flash_cs_n, o_flash_sck;
  logic        o_flash_mosi, i_flash_miso, o_load_done;
  logic [15:0] o_micro_wdata, i_micro_rdata;
  logic [7:0]  i_meas_fine, o_corr_fine;
  logic [31:0] o_bus_rdata, q;
  bus_req_t    i_bus;
  ev_desc_t    i_ev_desc;
  int          num_errors = 0;
  int          num_checks = 0;
  int          wait_n;

  aux_regs_flash_bridge_event_queue u_dut (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
    .o_bus_ack(o_bus_ack), .o_bus_rdata(o_bus_rdata),
    .i_lut_read_en(i_lut_read_en), .i_comp_en(i_comp_en),
    .i_evq_en(i_evq_en), .i_micro_read_ok(i_micro_read_ok),
    .i_micro_write_ok(i_micro_write_ok), .o_micro_wr(o_micro_wr),
    .o_micro_wdata(o_micro_wdata), .i_micro_rdata(i_micro_rdata),
    .i_ev_valid(i_ev_valid), .i_ev_desc(i_ev_desc),
    .o_ev_ready(o_ev_ready), .i_obuf_full(i_obuf_full),
    .o_board_full(o_board_full), .i_meas_valid(i_meas_valid),
    .i_meas_fine(i_meas_fine), .o_corr_valid(o_corr_valid),
    .o_corr_fine(o_corr_fine), .o_flash_cs_n(o_flash_cs_n),
    .o_flash_sck(o_flash_sck), .o_flash_mosi(o_flash_mosi),
    .i_flash_miso(i_flash_miso), .o_load_done(o_load_done));
  aux_flash_model u_flash (.i_cs_n(o_flash_cs_n), .i_sck(o_flash_sck),
    .i_mosi(o_flash_mosi), .o_miso(i_flash_miso));

  // Free-running 200 MHz board clock.
  initial begin
    i_mclk = 1'b0;
    forever #2.5 i_mclk = ~i_mclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d errors=%0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // One bus access: request held until the acknowledge edge, then dropped.
  task automatic acc(input logic r, input logic [15:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_bus <= '{rd: r, wr: !r, addr: a, wdata: d};
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_bus_ack !== 1'b1 && n < 300);
    q = o_bus_rdata;
    i_bus <= '0;
    if (o_bus_ack !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] exp);
    acc(1'b1, a, 32'h0);
    chk(q, exp);
  endtask

  // Offer one descriptor and hold it until the queue takes it.
  task automatic push(input logic [31:0] d);
    int n;
    @(posedge i_mclk);
    i_ev_valid <= 1'b1;
    i_ev_desc <= d;
    n = 0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_ev_ready !== 1'b1 && n < 50);
    i_ev_valid <= 1'b0;
    if (o_ev_ready !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  initial begin
    i_sys_rst = 1'b1;
    i_bus = '0;
    {i_lut_read_en, i_comp_en, i_evq_en, i_ev_valid} = 4'h0;
    {i_obuf_full, i_meas_valid, i_micro_write_ok} = 3'h0;
    i_micro_read_ok = 1'b1;
    i_micro_rdata = 16'hBEEF;
    i_ev_desc = '0;
    i_meas_fine = 8'h00;
    repeat (4) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    rd(OFS_CHIP_SELECT, 32'h1);
    rd(OFS_PAGE_SELECT, 32'h0);
    rd(OFS_HANDSHAKE, 32'h1);
    i_micro_read_ok <= 1'b0;
    i_micro_write_ok <= 1'b1;
    rd(OFS_HANDSHAKE, 32'h2);
    rd(OFS_EVQ_FLAGS, 32'h0);
    acc(1'b0, OFS_SCRATCH_WIDE, 32'hA5C31E7F);
    rd(OFS_SCRATCH_WIDE, 32'hA5C31E7F);
    acc(1'b0, OFS_SCRATCH_NARR, 32'h5A3C);
    rd(OFS_SCRATCH_NARR, 32'h5A3C);
    acc(1'b0, OFS_PAGE_SELECT, 32'hAB);
    rd(OFS_PAGE_SELECT, 32'hAB);
    rd(OFS_LUT_LO, 32'h0);
    rd(16'h1100, 32'h0);
    rd(OFS_BYTE_PORT, 32'h0);
    acc(1'b0, OFS_CMD_PORT, 32'h1234);
    i_micro_read_ok <= 1'b1;
    rd(OFS_CMD_PORT, 32'hBEEF);
    // Measurements with correction switched on and off.
    for (int k = 0; k < 4; k++) begin
      @(posedge i_mclk);
      i_comp_en <= k[1];
      i_meas_valid <= k[0];
      i_meas_fine <= 8'(k * 33);
    end
    @(posedge i_mclk);
    i_meas_valid <= 1'b0;
    i_obuf_full <= 1'b1;
    @(posedge i_mclk);
    i_obuf_full <= 1'b0;
    i_evq_en <= 1'b1;
    // Fill the queue to its limit, then drain it in order.
    for (int k = 0; k < EVQ_DEPTH; k++) push({k[15:0], 16'h0100 ^ k[15:0]});
    rd(OFS_EVQ_COUNT, 32'd1024);
    rd(OFS_EVQ_FLAGS, 32'h3);
    chk({31'h0, o_board_full}, 32'h1);
    @(posedge i_mclk);
    i_ev_valid <= 1'b1;
    repeat (2) @(posedge i_mclk);
    chk({31'h0, o_ev_ready}, 32'h0);
    i_ev_valid <= 1'b0;
    for (int k = 0; k < EVQ_DEPTH; k++)
      rd(OFS_EVQ_DATA, {k[15:0], 16'h0100 ^ k[15:0]});
    rd(OFS_EVQ_COUNT, 32'h0);
    rd(OFS_EVQ_FLAGS, 32'h0);
    // Let the loader finish page 0 and send the opcode and three address bytes of page 1.
    for (wait_n = 0; wait_n < 20000; wait_n++) begin
      if (u_flash.frames == 2 && u_flash.nbyte >= 4) break;
      @(posedge i_mclk);
    end
    if (wait_n == 20000) begin
      num_errors++;
      give_verdict();
    end
    chk({31'h0, o_load_done}, 32'h0);
    chk({24'h0, u_flash.rx[0]}, 32'hD2);
    // Page 1 sits at byte address 0x000200.
    for (int k = 1; k < 4; k++)
      chk({24'h0, u_flash.rx[k]}, (k == 2) ? 32'h2 : 32'h0);
    // Page 0 entry k holds (k + 8) ^ 0x3C from the flash model.
    acc(1'b0, OFS_PAGE_SELECT, 32'h0);
    i_lut_read_en <= 1'b1;
    rd(16'h8020, 32'h24);
    rd(OFS_LUT_HI, 32'h3B);
    i_comp_en <= 1'b1;
    i_meas_fine <= 8'h10;
    repeat (2) @(posedge i_mclk);
    chk({24'h0, o_corr_fine}, 32'h24);
    i_comp_en <= 1'b0;
    repeat (2) @(posedge i_mclk);
    chk({24'h0, o_corr_fine}, 32'h10);
    chk(u_flash.prog_bad, 32'h0);
    chk(u_flash.early_sel, 32'h0);
    acc(1'b0, OFS_CHIP_SELECT, 32'h0);
    rd(OFS_CHIP_SELECT, 32'h0);
    acc(1'b0, OFS_CHIP_SELECT, 32'h1);
    rd(OFS_CHIP_SELECT, 32'h1);
    give_verdict();
  end
endmodule
`default_nettype wire
